//--- verilog/lss_node_cfg.sv
/*
 Layer setting command handler for the node identifier: global state
 switch, configure node identifier, store configuration.
 Assumes received frames and the store port run on i_core_clk and
 that the stored configuration inputs are steady at reset release.
*/
module lss_node_cfg
    import lss_pkg::*;
(
    input  logic        i_core_clk,      // System clock, 200 MHz
    input  logic        i_sys_rst,       // Async reset, active high
    input  logic        i_rx_valid,      // Received frame pulse
    input  logic [10:0] i_rx_id,         // Received identifier
    input  logic [3:0]  i_rx_len,        // Received length
    input  logic [63:0] i_rx_data,       // Received payload
    output logic        o_tx_valid,      // Reply frame pending
    input  logic        i_tx_ready,      // Transmitter takes reply
    output logic [10:0] o_tx_id,         // Reply identifier
    output logic [3:0]  o_tx_len,        // Reply length
    output logic [63:0] o_tx_data,       // Reply payload
    input  logic        i_nv_valid,      // Stored config present
    input  logic [6:0]  i_nv_node_id,    // Stored node identifier
    input  logic [3:0]  i_nv_rate_idx,   // Stored bit rate index
    output logic        o_nv_wr_req,     // Store request, level
    input  logic        i_nv_ack,        // Store finished pulse
    output logic [6:0]  o_nv_node_id,    // Identifier to store
    output logic [3:0]  o_nv_rate_idx,   // Bit rate index to store
    output logic [6:0]  o_node_id,       // Active node identifier
    output logic [3:0]  o_rate_idx,      // Active bit rate index
    output logic        o_cfg_state,     // In configuration state
    output logic        o_node_reset     // Node reset pulse
);
    lss_state_t  state_q;
    lss_state_t  state_d;
    logic [6:0]  node_id_q;
    logic [6:0]  node_id_d;
    logic [6:0]  pend_id_q;
    logic [6:0]  pend_id_d;
    logic [3:0]  rate_q;
    logic [3:0]  rate_d;
    logic        nv_req_q;
    logic        nv_req_d;
    logic        rst_pulse_q;
    logic        rst_pulse_d;
    logic [7:0]  b0;
    logic [7:0]  b1;
    logic        sw_cmd;
    logic        cfg_cmd;
    logic        store_cmd;
    logic        sw_to_wait;
    logic        id_ok;

    lss_rsp_if u_rsp_if ();

    // Frame match on request identifier, length and specifier
    function automatic logic frame_is(
        input logic [10:0] id,
        input logic [3:0]  len,
        input logic [7:0]  cs,
        input logic [3:0]  want_len,
        input logic [7:0]  want_cs
    );
        frame_is = (id == LSS_REQ_ID) && (len == want_len) &&
                   (cs == want_cs);
    endfunction

    // Command decode; the master's framing is relied upon here
    assign b0         = i_rx_data[B0_LSB +: 8];
    assign b1         = i_rx_data[B1_LSB +: 8];
    assign sw_cmd     = i_rx_valid &&
        frame_is(i_rx_id, i_rx_len, b0, LEN_SWITCH, CS_SWITCH);
    assign cfg_cmd    = i_rx_valid &&
        frame_is(i_rx_id, i_rx_len, b0, LEN_CFG, CS_CFG_ID);
    assign store_cmd  = i_rx_valid &&
        frame_is(i_rx_id, i_rx_len, b0, LEN_STORE, CS_STORE);
    assign sw_to_wait = sw_cmd && (b1 == SW_WAIT);
    // Valid node identifiers are 1 to 127
    assign id_ok      = (b1[7] == 1'b0) && (b1[6:0] != 7'h00);

    // Handler state; replies only while the transmitter is idle
    always_comb
    begin
        state_d          = state_q;
        node_id_d        = node_id_q;
        pend_id_d        = pend_id_q;
        rate_d           = rate_q;
        nv_req_d         = nv_req_q;
        rst_pulse_d      = 1'b0;
        u_rsp_if.send    = 1'b0;
        u_rsp_if.cs      = CS_CFG_ID;
        u_rsp_if.err     = ERR_OK;
        case (state_q)
            ST_BOOT:
            begin
                // Stored values caught after release, not in reset
                if (i_nv_valid)
                begin
                    node_id_d = i_nv_node_id;
                    pend_id_d = i_nv_node_id;
                    rate_d    = i_nv_rate_idx;
                end
                else
                begin
                    node_id_d = DEF_NODE_ID;
                    pend_id_d = DEF_NODE_ID;
                    rate_d    = DEF_RATE_IDX;
                end
                state_d = ST_WAIT;
            end
            ST_WAIT:
            begin
                // Configure and store fall through untouched
                if (sw_cmd && (b1 == SW_CFG))
                begin
                    state_d = ST_CONFIG;
                end
            end
            ST_CONFIG:
            begin
                if (sw_to_wait)
                begin
                    node_id_d   = pend_id_q;
                    rst_pulse_d = 1'b1;
                    state_d     = ST_WAIT;
                end
                else if (cfg_cmd && !u_rsp_if.busy)
                begin
                    u_rsp_if.send = 1'b1;
                    if (id_ok)
                    begin
                        pend_id_d = b1[6:0];
                    end
                    else
                    begin
                        u_rsp_if.err = ERR_RANGE;
                    end
                end
                else if (store_cmd && !u_rsp_if.busy)
                begin
                    nv_req_d = 1'b1;
                    state_d  = ST_STORE;
                end
            end
            ST_STORE:
            begin
                // Frames during the write are dropped
                if (i_nv_ack)
                begin
                    nv_req_d      = 1'b0;
                    u_rsp_if.send = 1'b1;
                    u_rsp_if.cs   = CS_STORE;
                    state_d       = ST_CONFIG;
                end
            end
            default:
            begin
                state_d = ST_BOOT;
            end
        endcase
    end

    // Handler registers
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            state_q     <= ST_BOOT;
            node_id_q   <= DEF_NODE_ID;
            pend_id_q   <= DEF_NODE_ID;
            rate_q      <= DEF_RATE_IDX;
            nv_req_q    <= 1'b0;
            rst_pulse_q <= 1'b0;
        end
        else
        begin
            state_q     <= state_d;
            node_id_q   <= node_id_d;
            pend_id_q   <= pend_id_d;
            rate_q      <= rate_d;
            nv_req_q    <= nv_req_d;
            rst_pulse_q <= rst_pulse_d;
        end
    end

    // Reply transmitter
    lss_rsp_tx u_tx (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .rsp        (u_rsp_if.snk),
        .o_tx_valid (o_tx_valid),
        .i_tx_ready (i_tx_ready),
        .o_tx_id    (o_tx_id),
        .o_tx_len   (o_tx_len),
        .o_tx_data  (o_tx_data)
    );

    // Outputs; bit rate has no change path in this block
    assign o_nv_wr_req   = nv_req_q;
    assign o_nv_node_id  = pend_id_q;
    assign o_nv_rate_idx = rate_q;
    assign o_node_id     = node_id_q;
    assign o_rate_idx    = rate_q;
    assign o_cfg_state   = (state_q == ST_CONFIG) || (state_q == ST_STORE);
    assign o_node_reset  = rst_pulse_q;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);

    sequence s_store_start;
        (state_q == ST_CONFIG) && store_cmd && !u_rsp_if.busy && !sw_to_wait;
    endsequence
    sequence s_store_done;
        o_nv_wr_req && i_nv_ack;
    endsequence

    chk_default_id: assert property (
        (state_q == ST_BOOT) && !i_nv_valid |=> (o_node_id == DEF_NODE_ID))
        else $error("default node id not 127");
    chk_default_rate: assert property (
        (state_q == ST_BOOT) && !i_nv_valid |=> (o_rate_idx == DEF_RATE_IDX))
        else $error("default bit rate not 125 kbps");
    chk_id_only_lss: assert property (
        (state_q != ST_BOOT) && !((state_q == ST_CONFIG) && sw_to_wait)
        |=> $stable(o_node_id))
        else $error("node id changed outside command path");
    chk_enter_config: assert property (
        (state_q == ST_WAIT) && sw_cmd && (b1 == SW_CFG) |=> o_cfg_state)
        else $error("switch to config not taken");
    chk_cfg_reply: assert property (
        (state_q == ST_CONFIG) && cfg_cmd && !sw_to_wait && id_ok &&
        !o_tx_valid |=> o_tx_valid && (o_tx_data[7:0] == CS_CFG_ID) &&
        (o_tx_data[23:8] == 16'h0000) && (o_tx_id == LSS_RSP_ID) &&
        (o_tx_len == LEN_RSP) && (o_nv_node_id == $past(b1[6:0])))
        else $error("configure reply or pending id wrong");
    chk_store_req: assert property (
        s_store_start |=> o_nv_wr_req ##0 !o_tx_valid)
        else $error("store did not request write");
    chk_store_reply: assert property (
        s_store_done |=> o_tx_valid && !o_nv_wr_req &&
        (o_tx_data[7:0] == CS_STORE) && (o_tx_data[23:8] == 16'h0000))
        else $error("store reply wrong");
    chk_leave_reset: assert property (
        (state_q == ST_CONFIG) && sw_to_wait |=> o_node_reset ##0
        !o_cfg_state ##0 (o_node_id == $past(pend_id_q)) ##1 !o_node_reset)
        else $error("leave config did not reset node");
    chk_ignore_wait: assert property (
        (state_q == ST_WAIT) && !o_tx_valid |=> !o_tx_valid && !o_nv_wr_req)
        else $error("reply outside configuration state");
endmodule

//--- verilog/lss_pkg.sv
/*
 Shared constants and types for the node identifier configuration
 handler: frame identifiers, command specifiers, lengths and defaults.
 Assumes byte 0 of a CAN payload sits in data bits [7:0].
*/
package lss_pkg;
    // Frame identifiers
    localparam logic [10:0] LSS_REQ_ID      = 11'h7E5;
    localparam logic [10:0] LSS_RSP_ID      = 11'h7E4;
    // Command specifiers
    localparam logic [7:0]  CS_SWITCH       = 8'h04;
    localparam logic [7:0]  CS_CFG_ID       = 8'h11;
    localparam logic [7:0]  CS_STORE        = 8'h17;
    // Switch targets
    localparam logic [7:0]  SW_WAIT         = 8'h00;
    localparam logic [7:0]  SW_CFG          = 8'h01;
    // Frame lengths
    localparam logic [3:0]  LEN_SWITCH      = 4'h2;
    localparam logic [3:0]  LEN_CFG         = 4'h2;
    localparam logic [3:0]  LEN_STORE       = 4'h1;
    localparam logic [3:0]  LEN_RSP         = 4'h3;
    // Reply error codes
    localparam logic [7:0]  ERR_OK          = 8'h00;
    localparam logic [7:0]  ERR_RANGE       = 8'h01;
    // Factory defaults: node 127, 125 kbps (bit rate index 4)
    localparam logic [6:0]  DEF_NODE_ID     = 7'h7F;
    localparam int          DEF_RATE_KBPS   = 125;
    localparam logic [3:0]  DEF_RATE_IDX    = 4'h4;
    // Reply payload: bytes 2..7 are zero
    localparam logic [47:0] RSP_PAD         = 48'h0;
    // Payload byte positions
    localparam int          B0_LSB          = 0;
    localparam int          B1_LSB          = 8;

    typedef enum logic [1:0] {
        ST_BOOT,
        ST_WAIT,
        ST_CONFIG,
        ST_STORE
    } lss_state_t;
endpackage

//--- verilog/lss_rsp_if.sv
/*
 Reply request channel between the command handler and the reply
 transmitter. Assumes the source sends only while busy is low.
*/
interface lss_rsp_if;
    logic       send;   // One-cycle reply request
    logic [7:0] cs;     // Command specifier echoed
    logic [7:0] err;    // Error code byte
    logic       busy;   // Reply frame still pending

    modport src (output send, output cs, output err, input busy);
    modport snk (input send, input cs, input err, output busy);
endinterface

//--- verilog/lss_rsp_tx.sv
/*
 Holds one three-byte reply frame on identifier 0x7E4 until the CAN
 transmitter takes it. Assumes a valid/ready transmitter on i_core_clk.
*/
module lss_rsp_tx
    import lss_pkg::*;
(
    input  logic        i_core_clk,  // System clock
    input  logic        i_sys_rst,   // Async reset, active high
    lss_rsp_if.snk      rsp,         // Reply requests
    output logic        o_tx_valid,  // Reply frame pending
    input  logic        i_tx_ready,  // Transmitter takes frame
    output logic [10:0] o_tx_id,     // Reply identifier
    output logic [3:0]  o_tx_len,    // Reply length
    output logic [63:0] o_tx_data    // Reply payload
);
    logic        valid_q;
    logic        valid_d;
    logic [63:0] data_q;
    logic [63:0] data_d;

    // Next frame; a new request only comes while idle
    always_comb
    begin
        valid_d = valid_q;
        data_d  = data_q;
        if (valid_q && i_tx_ready)
        begin
            valid_d = 1'b0;
        end
        if (rsp.send)
        begin
            valid_d = 1'b1;
            data_d  = {RSP_PAD, rsp.err, rsp.cs};
        end
    end

    // Frame registers
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            valid_q <= 1'b0;
            data_q  <= 64'h0;
        end
        else
        begin
            valid_q <= valid_d;
            data_q  <= data_d;
        end
    end

    // Identifier and length never vary
    assign o_tx_id    = LSS_RSP_ID;
    assign o_tx_len   = LEN_RSP;
    assign o_tx_valid = valid_q;
    assign o_tx_data  = data_q;
    assign rsp.busy   = valid_q;
endmodule

//--- testbench/lss_far_model.sv
/*
 Far-side model: the CAN transmitter that takes replies and the
 non-volatile store that acknowledges each write request without keeping any data.
 Assumes the handler holds each request until it is answered.
*/
module lss_far_model (
    input  logic i_core_clk,  // System clock
    input  logic i_sys_rst,   // Async reset, active high
    input  logic i_slow,      // Stretch every answer
    input  logic i_tx_valid,  // Reply frame pending
    output logic o_tx_ready,  // Reply frame taken
    input  logic i_wr_req,    // Store request
    output logic o_nv_ack     // Store finished
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] tx_cnt_q;
    logic [3:0] nv_cnt_q;
    logic [3:0] lim;

    // Slow answers model a busy bus and a slow flash write
    assign lim = i_slow ? 4'h6 : 4'h0;

    // Answer only while a request stands, one cycle each
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            tx_cnt_q   <= 4'h0;
            nv_cnt_q   <= 4'h0;
            o_tx_ready <= 1'b0;
            o_nv_ack   <= 1'b0;
        end
        else
        begin
            tx_cnt_q   <= (i_tx_valid && !o_tx_ready) ? tx_cnt_q + 4'h1 : 4'h0;
            o_tx_ready <= i_tx_valid && !o_tx_ready && (tx_cnt_q >= lim);
            nv_cnt_q   <= (i_wr_req && !o_nv_ack) ? nv_cnt_q + 4'h1 : 4'h0;
            o_nv_ack   <= i_wr_req && !o_nv_ack && (nv_cnt_q >= lim);
        end
    end
endmodule

//--- testbench/lss_node_id_config_bench.sv
/*
 Self-checking bench for the node identifier handler.
 Assumes the far-side model answers replies and store requests.
*/
module lss_node_id_config_bench;
    import lss_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        rx_valid = 1'b0;
    logic [10:0] rx_id = 11'h000;
    logic [3:0]  rx_len = 4'h0;
    logic [63:0] rx_data = 64'h0;
    logic        slow = 1'b0;
    logic        nv_in_valid = 1'b0;
    logic [6:0]  nv_in_node = 7'h00;
    logic [3:0]  nv_in_rate = 4'h0;
    logic        tx_valid, tx_ready, wr_req, nv_ack, cfg, nrst;
    logic [10:0] tx_id;
    logic [3:0]  tx_len, rate, nv_rate;
    logic [63:0] tx_data;
    logic [6:0]  node, nv_node;
    int          error_cnt = 0;
    int          checks = 0;

    // 200 MHz clock
    always #2.5 clk = ~clk;

    lss_node_cfg dut (
        .i_core_clk(clk), .i_sys_rst(rst), .i_rx_valid(rx_valid),
        .i_rx_id(rx_id), .i_rx_len(rx_len), .i_rx_data(rx_data),
        .o_tx_valid(tx_valid), .i_tx_ready(tx_ready), .o_tx_id(tx_id),
        .o_tx_len(tx_len), .o_tx_data(tx_data), .i_nv_valid(nv_in_valid),
        .i_nv_node_id(nv_in_node), .i_nv_rate_idx(nv_in_rate),
        .o_nv_wr_req(wr_req),
        .i_nv_ack(nv_ack), .o_nv_node_id(nv_node), .o_nv_rate_idx(nv_rate),
        .o_node_id(node), .o_rate_idx(rate), .o_cfg_state(cfg),
        .o_node_reset(nrst)
    );

    lss_far_model far (
        .i_core_clk(clk), .i_sys_rst(rst), .i_slow(slow),
        .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
        .i_wr_req(wr_req), .o_nv_ack(nv_ack)
    );

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One master frame; it is taken at the second edge
    task automatic send(input logic [3:0] len, input logic [15:0] d);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_id    <= LSS_REQ_ID;
        rx_len   <= len;
        rx_data  <= {48'h0, d};
        @(posedge clk);
        rx_valid <= 1'b0;
        #1;
    endtask

    // Bounded wait for the reply handshake, then judge the frame
    task automatic wait_reply(input logic [7:0] cs, input logic [7:0] err);
        bit got;
        got = 1'b0;
        for (int i = 0; i < 40 && !got; i++)
        begin
            // Settled values; a high pair means taken at the next edge
            @(posedge clk);
            #1;
            if (tx_valid === 1'b1 && tx_ready === 1'b1)
            begin
                got = 1'b1;
                chk(tx_data, {40'h0, 8'h00, err, cs});
                chk({49'h0, tx_id, tx_len}, {49'h0, LSS_RSP_ID, LEN_RSP});
            end
        end
        if (!got)
        begin
            error_cnt++;
            give_verdict();
        end
    endtask

    task automatic t_boot();
        chk({57'h0, node}, {57'h0, 7'h7F});
        chk({60'h0, rate}, {60'h0, DEF_RATE_IDX});
        $display("test boot done");
    endtask

    // Configure and store outside configuration state: silence
    task automatic t_refuse();
        send(LEN_CFG, {8'h2A, CS_CFG_ID});
        send(LEN_STORE, {8'h00, CS_STORE});
        for (int i = 0; i < 10; i++)
        begin
            @(posedge clk);
            #1;
            chk({62'h0, tx_valid, wr_req}, 64'h0);
        end
        chk({57'h0, nv_node}, {57'h0, 7'h7F});
        $display("test refuse done");
    endtask

    task automatic t_enter();
        send(LEN_SWITCH, {SW_CFG, CS_SWITCH});
        chk({63'h0, cfg}, 64'h1);
        $display("test enter done");
    endtask

    // Out of range id first, then a good one, with a slow transmitter
    task automatic t_config();
        slow <= 1'b1;
        send(LEN_CFG, {8'h00, CS_CFG_ID});
        wait_reply(CS_CFG_ID, ERR_RANGE);
        send(LEN_CFG, {8'h2A, CS_CFG_ID});
        wait_reply(CS_CFG_ID, ERR_OK);
        #1;
        chk({57'h0, nv_node}, {57'h0, 7'h2A});
        chk({57'h0, node}, {57'h0, 7'h7F});
        $display("test config done");
    endtask

    task automatic t_store();
        send(LEN_STORE, {8'h00, CS_STORE});
        chk({62'h0, wr_req, cfg}, 64'h3);
        chk({60'h0, nv_rate}, {60'h0, DEF_RATE_IDX});
        wait_reply(CS_STORE, ERR_OK);
        #1;
        chk({63'h0, wr_req}, 64'h0);
        $display("test store done");
    endtask

    task automatic t_leave();
        send(LEN_SWITCH, {SW_WAIT, CS_SWITCH});
        chk({62'h0, nrst, cfg}, 64'h2);
        chk({57'h0, node}, {57'h0, 7'h2A});
        @(posedge clk);
        #1;
        chk({63'h0, nrst}, 64'h0);
        $display("test leave done");
    endtask

    // Mid-run reset with a stored configuration present
    task automatic t_reboot();
        @(posedge clk);
        nv_in_valid <= 1'b1;
        nv_in_node  <= 7'h2A;
        nv_in_rate  <= 4'h3;
        rst         <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({57'h0, node}, {57'h0, 7'h7F});
        chk({62'h0, cfg, nrst}, 64'h0);
        @(posedge clk);
        #1;
        chk({57'h0, node}, {57'h0, 7'h2A});
        chk({60'h0, rate}, {60'h0, 4'h3});
        chk({62'h0, tx_valid, wr_req}, 64'h0);
        $display("test reboot done");
    endtask

    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        t_boot();
        t_refuse();
        t_enter();
        t_config();
        t_store();
        t_leave();
        t_reboot();
        give_verdict();
    end
endmodule
